// ===== logic/msu_pkg.sv
// Constants and types of the multi-bit shift unit.
// Assumes a 32-bit APB slave port and a 25 MHz single clock.
// Notes on behaviour
// - Function code 580 is word left shift, 582 is double-word left.
// - Function code 581 is word right shift, 583 is double-word right.
// - Word left shift moves the 16-bit operand toward its top end.
// - Double left shift treats low and high words as one 32-bit value.
// - Word right shift moves the 16-bit operand toward bit zero.
// - Double right shift moves the 32-bit pair toward bit zero.
// - Shift count comes from the low eight bits of the control word.
// - Left shifts fill vacated low bits with zeros or original bit zero.
// - Right shifts with edge fill copy the original top bit downward.
// - Carry takes the last bit shifted out; other shifted-out bits vanish.
// - Error flag set when count is out of range, cleared otherwise.
// - Equals flag set when the shifted result is all zeros.
// - Negative flag set when the top bit of the result is one.
// - Count zero leaves data unchanged but still updates the flags.
`default_nettype none
package msu_pkg;
    localparam logic [9:0] MSU_FC_WORD_LEFT = 10'd580;
    localparam logic [9:0] MSU_FC_WORD_RIGHT = 10'd581;
    localparam logic [9:0] MSU_FC_DWORD_LEFT = 10'd582;
    localparam logic [9:0] MSU_FC_DWORD_RIGHT = 10'd583;
    localparam int MSU_COUNT_LSB = 0;
    localparam int MSU_COUNT_W = 8;
    localparam int MSU_FILL_BIT = 8;
    localparam logic [7:0] MSU_WORD_MAX = 8'h10;
    localparam logic [7:0] MSU_DWORD_MAX = 8'h20;
    localparam logic [7:0] MSU_OFS_CTRL = 8'h00;
    localparam logic [7:0] MSU_OFS_STATUS = 8'h04;
    localparam logic [7:0] MSU_OFS_MASK = 8'h08;
    localparam logic [7:0] MSU_OFS_RESULT = 8'h0C;
    localparam logic [7:0] MSU_OFS_FLAGS = 8'h10;
    localparam int MSU_EV_DONE = 0;
    localparam int MSU_EV_ERROR = 1;
    localparam int MSU_EV_BADCODE = 2;
    localparam int MSU_EV_W = 3;
    localparam logic MSU_CTRL_EN_RST = 1'b1;
    localparam logic [2:0] MSU_MASK_RST = 3'h0;
    typedef struct packed {
        logic ctrl_en;
        logic [MSU_EV_W-1:0] mask;
        logic [MSU_EV_W-1:0] status;
        logic [31:0] result;
        logic error_flag;
        logic zero_result_flag;
        logic carry_flag;
        logic negative_flag;
        logic done;
        logic exec_prev;
        logic [31:0] prdata;
        logic pslverr;
    } msu_state_type;
endpackage
`default_nettype wire

// ===== logic/msu_shift_unit.sv
// Multi-bit shift execution unit with an APB register window.
// Assumes the sequencer holds operands stable while exec_i is sampled.
`timescale 1ns/1ps
`default_nettype none
module msu_shift_unit (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Sequencer request
    input wire logic exec_i,
    input wire logic edge_mode_i,
    input wire logic [9:0] func_code_i,
    input wire logic [15:0] operand_lo_i,
    input wire logic [15:0] operand_hi_i,
    input wire logic [15:0] control_i,
    // Sequencer answer
    output logic done_o,
    output logic [15:0] result_lo_o,
    output logic [15:0] result_hi_o,
    output logic error_flag_o,
    output logic zero_result_flag_o,
    output logic carry_flag_o,
    output logic negative_flag_o,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Interrupt
    output logic irq_o
);
    import msu_pkg::*;

    msu_state_type st_r;
    msu_state_type st_nxt;

    // Returns {carry, result}; single words live in the low half
    function automatic logic [32:0] msu_shift(input logic [31:0] v,
                                              input logic [7:0] n,
                                              input logic left,
                                              input logic dbl,
                                              input logic edge_fill);
        logic [63:0] ext;
        logic [31:0] res;
        logic [31:0] fill;
        logic cy;
        logic top;
        ext = 64'h0;
        res = 32'h0;
        fill = 32'h0;
        cy = 1'b0;
        top = dbl ? v[31] : v[15];
        if (left) begin
            ext = {32'h0, v} << n;
            fill = ~(32'hFFFFFFFF << n);
            res = ext[31:0];
            if (edge_fill && v[0]) begin
                res = res | fill;
            end
            cy = dbl ? ext[32] : ext[16];
            if (!dbl) begin
                res[31:16] = 16'h0;
            end
        end else if (dbl) begin
            ext = {v, 32'h0} >> n;
            fill = ~(32'hFFFFFFFF >> n);
            res = ext[63:32];
            if (edge_fill && top) begin
                res = res | fill;
            end
            cy = ext[31];
        end else begin
            ext = {v[15:0], 48'h0} >> n;
            fill = {16'h0, ~(16'hFFFF >> n)};
            res = {16'h0, ext[63:48]};
            if (edge_fill && top) begin
                res = res | fill;
            end
            cy = ext[47];
        end
        return {cy, res};
    endfunction

    logic fire;
    logic is_left;
    logic is_dbl;
    logic code_ok;
    logic [7:0] count;
    logic [7:0] count_max;
    logic [31:0] operand;
    logic [32:0] shifted;
    logic wr_acc;
    logic rd_setup;
    logic [7:0] ev;

    always_comb begin
        is_left = 1'b0;
        is_dbl = 1'b0;
        code_ok = 1'b1;
        if (func_code_i == MSU_FC_WORD_LEFT) begin
            is_left = 1'b1;
        end else if (func_code_i == MSU_FC_DWORD_LEFT) begin
            is_left = 1'b1;
            is_dbl = 1'b1;
        end else if (func_code_i == MSU_FC_WORD_RIGHT) begin
            is_left = 1'b0;
        end else if (func_code_i == MSU_FC_DWORD_RIGHT) begin
            is_dbl = 1'b1;
        end else begin
            code_ok = 1'b0;
        end
    end

    // Edge mode runs once per rising edge of the execution condition
    assign fire = st_r.ctrl_en && exec_i && (!edge_mode_i || !st_r.exec_prev);
    assign count = control_i[MSU_COUNT_LSB +: MSU_COUNT_W];
    assign count_max = is_dbl ? MSU_DWORD_MAX : MSU_WORD_MAX;
    // High word in the top half, low word in the bottom half
    assign operand = is_dbl ? {operand_hi_i, operand_lo_i}
                            : {16'h0, operand_lo_i};
    assign shifted = msu_shift(operand, count, is_left, is_dbl,
                               control_i[MSU_FILL_BIT]);
    assign wr_acc = psel_i && penable_i && pwrite_i;
    assign rd_setup = psel_i && !penable_i;

    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        st_nxt.exec_prev = exec_i;
        ev = 8'h00;
        if (fire && code_ok) begin
            st_nxt.done = 1'b1;
            ev[MSU_EV_DONE] = 1'b1;
            if (count > count_max) begin
                // Bad count keeps the old data and other flags
                st_nxt.error_flag = 1'b1;
                ev[MSU_EV_ERROR] = 1'b1;
            end else begin
                st_nxt.error_flag = 1'b0;
                // Count zero falls out of the shifter as unchanged data
                st_nxt.result = shifted[31:0];
                st_nxt.carry_flag = (count != 8'h00) && shifted[32];
                st_nxt.zero_result_flag = is_dbl ? (shifted[31:0] == 32'h0)
                    : (shifted[15:0] == 16'h0);
                st_nxt.negative_flag = is_dbl ? shifted[31]
                    : shifted[15];
            end
        end else if (fire) begin
            ev[MSU_EV_BADCODE] = 1'b1;
        end
        // Register writes; hardware set wins over a write-one clear
        if (wr_acc) begin
            if (paddr_i == MSU_OFS_CTRL) begin
                st_nxt.ctrl_en = pwdata_i[0];
            end else if (paddr_i == MSU_OFS_STATUS) begin
                st_nxt.status = st_r.status & ~pwdata_i[MSU_EV_W-1:0];
            end else if (paddr_i == MSU_OFS_MASK) begin
                st_nxt.mask = pwdata_i[MSU_EV_W-1:0];
            end
        end
        st_nxt.status = st_nxt.status | ev[MSU_EV_W-1:0];
        // Read data is captured in setup so the access needs no wait
        if (rd_setup) begin
            st_nxt.pslverr = 1'b0;
            st_nxt.prdata = 32'h0;
            if (paddr_i == MSU_OFS_CTRL) begin
                st_nxt.prdata = {31'h0, st_r.ctrl_en};
            end else if (paddr_i == MSU_OFS_STATUS) begin
                st_nxt.prdata = {29'h0, st_r.status};
            end else if (paddr_i == MSU_OFS_MASK) begin
                st_nxt.prdata = {29'h0, st_r.mask};
            end else if (paddr_i == MSU_OFS_RESULT) begin
                st_nxt.prdata = st_r.result;
            end else if (paddr_i == MSU_OFS_FLAGS) begin
                st_nxt.prdata = {28'h0, st_r.negative_flag, st_r.carry_flag,
                                 st_r.zero_result_flag, st_r.error_flag};
            end else begin
                st_nxt.pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_r <= '0;
            st_r.ctrl_en <= MSU_CTRL_EN_RST;
            st_r.mask <= MSU_MASK_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign done_o = st_r.done;
    assign result_lo_o = st_r.result[15:0];
    assign result_hi_o = st_r.result[31:16];
    assign error_flag_o = st_r.error_flag;
    assign zero_result_flag_o = st_r.zero_result_flag;
    assign carry_flag_o = st_r.carry_flag;
    assign negative_flag_o = st_r.negative_flag;
    assign prdata_o = st_r.prdata;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && st_r.pslverr;
    assign irq_o = |(st_r.status & st_r.mask);
endmodule // msu_shift_unit
`default_nettype wire

// ===== bench/msu_seq_model.sv
// Sequencer model: presents operands and the execution condition.
// Assumes its task is called from one bench process at a time.
`timescale 1ns/1ps
`default_nettype none
module msu_seq_model (
    // Clock
    input wire logic mclk_i,
    // Request
    output logic exec_o,
    output logic [9:0] fc_o,
    output logic [15:0] lo_o,
    output logic [15:0] hi_o,
    output logic [15:0] ctl_o
);
    initial begin
        exec_o = 1'b0;
        fc_o = 10'h000;
        {hi_o, lo_o} = 32'h0;
        ctl_o = 16'h0000;
    end
    // Released operands are scrambled, never left showing
    task automatic issue(input logic [9:0] f, input logic [31:0] v,
                         input logic [15:0] c, input int n);
        @(posedge mclk_i);
        exec_o <= 1'b1;
        fc_o <= f;
        {hi_o, lo_o} <= v;
        ctl_o <= c;
        repeat (n) @(posedge mclk_i);
        exec_o <= 1'b0;
        fc_o <= ~f;
        {hi_o, lo_o} <= ~v;
        ctl_o <= ~c;
    endtask
endmodule // msu_seq_model
`default_nettype wire

// ===== bench/msu_shift_unit_chk.sv
// Port checks of the shift unit, bound to its top module.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module msu_shift_unit_chk (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Sequencer side
    input wire logic exec_i,
    input wire logic [9:0] func_code_i,
    input wire logic [15:0] operand_lo_i,
    input wire logic [15:0] operand_hi_i,
    input wire logic [15:0] control_i,
    input wire logic done_o,
    input wire logic [15:0] result_lo_o,
    input wire logic [15:0] result_hi_o,
    input wire logic error_flag_o,
    input wire logic zero_result_flag_o,
    input wire logic carry_flag_o,
    input wire logic negative_flag_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    wire dbl = func_code_i[1];
    wire rgt = func_code_i[0];
    wire [7:0] cnt = control_i[7:0];
    wire msb = dbl ? operand_hi_i[15] : operand_lo_i[15];
    wire ok = done_o && !error_flag_o;
    wire code_ok = func_code_i >= 10'd580 && func_code_i <= 10'd583;
    property p_bad; exec_i && !code_ok |=> !done_o; endproperty
    a_bad: assert property (p_bad) else $error("bad code done");
    property p_err;
        done_o |-> error_flag_o == ($past(cnt) > ($past(dbl) ? 32 : 16));
    endproperty
    a_err: assert property (p_err) else $error("error flag");
    property p_zero;
        ok |-> zero_result_flag_o == ({result_hi_o, result_lo_o} == 32'h0);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag");
    property p_neg;
        ok |-> negative_flag_o ==
            ($past(dbl) ? result_hi_o[15] : result_lo_o[15]);
    endproperty
    a_neg: assert property (p_neg) else $error("negative flag");
    property p_zc;
        ok && $past(cnt) == 8'h00 |-> result_lo_o == $past(operand_lo_i);
    endproperty
    a_zc: assert property (p_zc) else $error("count zero");
    property p_fill; ok && !$past(rgt) && $past(cnt) != 8'h00 |->
        result_lo_o[0] == ($past(control_i[8]) & $past(operand_lo_i[0]));
    endproperty
    a_fill: assert property (p_fill) else $error("left fill");
    property p_edge; ok && $past(rgt) && $past(control_i[8]) &&
        $past(cnt) != 8'h00 |-> negative_flag_o == $past(msb);
    endproperty
    a_edge: assert property (p_edge) else $error("right fill");
    property p_cy;
        ok && !$past(rgt) && $past(cnt) == 8'h01 |-> carry_flag_o == $past(msb);
    endproperty
    a_cy: assert property (p_cy) else $error("carry");
    c_err: cover property (done_o && error_flag_o);
    c_neg: cover property (ok && negative_flag_o);
    c_zero: cover property (ok && zero_result_flag_o);
endmodule // msu_shift_unit_chk
bind msu_shift_unit msu_shift_unit_chk u_chk (.mclk_i, .resetn_i, .exec_i,
    .func_code_i, .operand_lo_i, .operand_hi_i, .control_i, .done_o,
    .result_lo_o, .result_hi_o, .error_flag_o, .zero_result_flag_o,
    .carry_flag_o, .negative_flag_o);
`default_nettype wire

// ===== bench/tb_msu_shift_unit.sv
// Self-checking bench of the shift unit: sequencer model and APB tasks.
// Assumes zero-wait APB and a one-cycle answer on the sequencer port.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
    err_total++; $display("Error %s expected %h seen %h", n, e, g); end end
module tb_msu_shift_unit;
    import msu_pkg::*;
    logic mclk_i = 1'b0, resetn_i = 1'b0, edge_mode_i = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd, er;
    logic exec_i, done_o, error_flag_o, zero_result_flag_o, carry_flag_o;
    logic negative_flag_o, pready_o, pslverr_o, irq_o, ec, ez, en, se;
    logic [9:0] func_code_i;
    logic [15:0] operand_lo_i, operand_hi_i, control_i, result_lo_o;
    logic [15:0] result_hi_o;
    logic [33:0] m;
    logic [7:0] cnts [7] = '{8'h00, 8'h01, 8'h0A, 8'h10, 8'h11, 8'h20, 8'h21};
    int err_total = 0, compares = 0, dones = 0, d0;
    always #20 mclk_i = ~mclk_i;
    always @(posedge mclk_i) if (done_o === 1'b1) dones <= dones + 1;
    msu_seq_model u_seq (.mclk_i(mclk_i), .exec_o(exec_i), .fc_o(func_code_i),
        .lo_o(operand_lo_i), .hi_o(operand_hi_i), .ctl_o(control_i));
    msu_shift_unit u_dut (.*);
    function automatic logic [33:0] ref_shift(logic [9:0] f, logic [31:0] v,
                                              logic [15:0] c);
        int w;
        logic [31:0] r;
        logic y;
        w = f[1] ? 32 : 16;
        if (!f[1]) v[31:16] = 16'h0000;
        r = v;
        y = 1'b0;
        for (int i = 0; i < c[7:0]; i++) begin
            y = f[0] ? r[0] : r[w-1];
            r = f[0] ? r >> 1 : r << 1;
            if (c[8]) r[f[0] ? w-1 : 0] = f[0] ? v[w-1] : v[0];
        end
        if (!f[1]) r[31:16] = 16'h0000;
        return {c[7:0] > w, y, r};
    endfunction
    task automatic end_of_test();
        $display("Compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do @(posedge mclk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        se = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic op(input logic [9:0] f, input logic [31:0] v,
                      input logic [15:0] c);
        m = ref_shift(f, v, c);
        u_seq.issue(f, v, c, 1);
        @(negedge mclk_i);
        `CHK("done", 1'b1, done_o)
        `CHK("error", m[33], error_flag_o)
        if (!m[33]) {er, ec, ez, en} = {m[31:0], m[32], m[31:0] == 0,
                                        f[1] ? m[31] : m[15]};
        `CHK("result", er, {result_hi_o, result_lo_o})
        `CHK("flags", {ec, ez, en}, {carry_flag_o, zero_result_flag_o,
             negative_flag_o})
    endtask
    initial begin
        {er, ec, ez, en} = 35'h0;
        repeat (5) @(posedge mclk_i);
        resetn_i <= 1'b1;
        apb(1'b0, MSU_OFS_CTRL, 32'h0);
        `CHK("ctrl", 32'h1, rd)
        apb(1'b1, MSU_OFS_MASK, 32'h7);
        for (int i = 0; i < 4; i++)
            for (int j = 0; j < 14; j++)
                op(10'd580 + i, j[0] ? 32'hC3A5_8001 : 32'h0000_4003,
                   {7'h00, j >= 7, cnts[j % 7]});
        apb(1'b0, MSU_OFS_FLAGS, 32'h0);
        `CHK("flags reg", {28'h0, en, ec, ez, 1'b1}, rd)
        apb(1'b0, 8'h14, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        `CHK("pslverr", 1'b1, se)
        d0 = dones;
        u_seq.issue(10'd584, 32'h1, 16'h0004, 1);
        apb(1'b0, MSU_OFS_STATUS, 32'h0);
        `CHK("status", 32'h7, rd)
        `CHK("irq", 1'b1, irq_o)
        apb(1'b1, MSU_OFS_STATUS, 32'h7);
        @(negedge mclk_i);
        `CHK("irq clr", 1'b0, irq_o)
        @(posedge mclk_i) edge_mode_i <= 1'b1;
        u_seq.issue(10'd581, 32'h8000, 16'h0104, 3);
        @(negedge mclk_i);
        `CHK("edge word", 32'h0000_F800, {result_hi_o, result_lo_o})
        @(posedge mclk_i) edge_mode_i <= 1'b0;
        u_seq.issue(10'd583, 32'h8000_0000, 16'h0101, 3);
        repeat (2) @(negedge mclk_i);
        `CHK("dones", 32'd4, dones - d0)
        `CHK("dword", 32'hC000_0000, {result_hi_o, result_lo_o})
        end_of_test();
    end
    initial begin
        #400000;
        err_total++;
        end_of_test();
    end
endmodule // tb_msu_shift_unit
`default_nettype wire
